// *** pse_voltage_foldback_regs.sv ***
// Voltage telemetry, foldback selection and firmware revision register slice
//
// Summary of operation
// - Channel 3 voltage: 3Ah, low byte first
// - Channel 4 voltage: 3Eh, low byte first
// - Voltage is 14-bit count, resets zero
// - Double-foldback bit raises limit thresholds
// - Fault timer starts on exceeding limit
// - Inrush profile ignores double-foldback bits
// - Fault time nominal, or programmed if doubled
// - Turn-on sets double-foldback for class >= 4
// - Single signature sets both; dual per channel
// - Hold bit blocks automatic turn-on adjustment
// - Turn-off restores policing and double-foldback
// - Four-pair: either hold bit blocks both
// - Turn-off clears the hold bit
// - Double-foldback bits act per channel only
// - Selection register: 40h, read/write, resets zero
// - Firmware revision: 41h, one byte, read-only
`timescale 1ns/1ps
`default_nettype none
`include "pse_fb_cfg.svh"

module pse_voltage_foldback_regs #(
	parameter logic [`FAULT_CNT_WIDTH-1:0] NOM_FAULT_CYCLES = `FAULT_CNT_WIDTH'(`NOM_FAULT_CYCLES)
) (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic cmd_start_in,
	input wire logic [7:0] cmd_code_in,
	input wire logic wr_strobe_in,
	input wire logic [7:0] wr_byte_in,
	input wire logic rd_strobe_in,
	output logic [7:0] rd_byte_out,
	output logic rd_valid_out,
	input wire logic ch3_volt_sample_in,
	input wire logic [`VOLT_WIDTH-1:0] ch3_volt_count_in,
	input wire logic ch4_volt_sample_in,
	input wire logic [`VOLT_WIDTH-1:0] ch4_volt_count_in,
	input wire logic fw_load_in,
	input wire logic [7:0] fw_revision_in,
	input wire logic [3:0] port_turn_on_in,
	input wire logic [3:0] port_turn_off_in,
	input wire logic [15:0] assigned_class_in,
	input wire logic [1:0] four_pair_in,
	input wire logic [1:0] single_signature_in,
	input wire logic [3:0] inrush_active_in,
	input wire logic [3:0] over_limit_in,
	input wire logic [`FAULT_CNT_WIDTH-1:0] prog_fault_cycles_in,
	output logic [3:0] double_foldback_enable_out,
	output logic [3:0] manual_policing_hold_out,
	output logic [31:0] power_cut_policing_limit_out,
	output pse_fb_pkg::thr_vec_t current_limit_threshold_out,
	output logic [3:0] limit_fault_out
);
	import pse_fb_pkg::*;

	////////////////////////////////////////////////////////////////////////////////

	function automatic logic [3:0] class_of(input logic [15:0] classes, input int ch);
		class_of = classes[ch*4 +: 4];
	endfunction : class_of

	function automatic logic [7:0] pcut_from_class(input logic [3:0] cls);
		logic [11:0] product;
		product = {8'h00, cls} * {4'h0, `PCUT_STEP};
		pcut_from_class = (product > 12'h0ff) ? `PCUT_DEFAULT : product[7:0];
	endfunction : pcut_from_class

	function automatic logic [7:0] volt_low(input logic [`VOLT_WIDTH-1:0] count);
		volt_low = count[7:0];
	endfunction : volt_low

	function automatic logic [7:0] volt_high(input logic [`VOLT_WIDTH-1:0] count);
		volt_high = {2'b00, count[13:8]};
	endfunction : volt_high

	////////////////////////////////////////////////////////////////////////////////

	slice_state_t state_q;
	slice_state_t state_d;
	logic [`VOLT_WIDTH-1:0] ch3_count;
	logic [`VOLT_WIDTH-1:0] ch4_count;
	logic [3:0] hold_eff;
	logic [3:0] fault_raw;

	volt_telemetry_word u_ch3_volt (
		.clock_in(clock_in),
		.rst_n_in(rst_n_in),
		.sample_in(ch3_volt_sample_in),
		.sample_count_in(ch3_volt_count_in),
		.count_out(ch3_count)
	);

	volt_telemetry_word u_ch4_volt (
		.clock_in(clock_in),
		.rst_n_in(rst_n_in),
		.sample_in(ch4_volt_sample_in),
		.sample_count_in(ch4_volt_count_in),
		.count_out(ch4_count)
	);

	genvar gc;
	generate
		for (gc = 0; gc < 4; gc = gc + 1) begin : g_timer
			limit_fault_timer #(
				.NOM_CYCLES(NOM_FAULT_CYCLES)
			) u_timer (
				.clock_in(clock_in),
				.rst_n_in(rst_n_in),
				.over_limit_in(over_limit_in[gc]),
				.double_fb_in(state_q.fold_sel[`FOLD_DFB_LSB + gc]),
				.prog_cycles_in(prog_fault_cycles_in),
				.fault_out(fault_raw[gc])
			);
		end
	endgenerate

	// Four-pair ports share hold: either channel's bit blocks both
	always_comb begin
		for (int c = 0; c < 4; c++) begin
			hold_eff[c] = state_q.fold_sel[`FOLD_HOLD_LSB + c]
				| (four_pair_in[c/2] & state_q.fold_sel[`FOLD_HOLD_LSB + (c ^ 1)]);
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	always_comb begin
		state_d = state_q;
		state_d.rd_valid = 1'b0;

		// Host byte access
		if (cmd_start_in) begin
			state_d.cmd = cmd_code_in;
			state_d.idx = IDX_LOW;
		end else if (rd_strobe_in) begin
			state_d.rd_valid = 1'b1;
			state_d.idx = IDX_HIGH;
			state_d.rd_data = `READ_IDLE_BYTE;
			unique case (state_q.cmd)
				`CMD_CH3_VOLTAGE: begin
					if (state_q.idx == IDX_LOW) begin
						// Snapshot the top byte so the pair stays coherent
						state_d.rd_data = volt_low(ch3_count);
						state_d.msb_hold = volt_high(ch3_count);
					end else begin
						state_d.rd_data = state_q.msb_hold;
						state_d.msb_hold = `READ_IDLE_BYTE;
					end
				end
				`CMD_CH4_VOLTAGE: begin
					if (state_q.idx == IDX_LOW) begin
						state_d.rd_data = volt_low(ch4_count);
						state_d.msb_hold = volt_high(ch4_count);
					end else begin
						state_d.rd_data = state_q.msb_hold;
						state_d.msb_hold = `READ_IDLE_BYTE;
					end
				end
				`CMD_FOLD_SELECT: begin
					if (state_q.idx == IDX_LOW) begin
						state_d.rd_data = state_q.fold_sel;
					end
				end
				`CMD_FW_REVISION: begin
					if (state_q.idx == IDX_LOW) begin
						state_d.rd_data = state_q.fw_rev;
					end
				end
				default: begin
					state_d.rd_data = `READ_IDLE_BYTE;
				end
			endcase
		end else if (wr_strobe_in) begin
			state_d.idx = IDX_HIGH;
			// Voltage and revision have no write path
			if (state_q.cmd == `CMD_FOLD_SELECT && state_q.idx == IDX_LOW) begin
				state_d.fold_sel = wr_byte_in;
			end
		end

		if (fw_load_in) begin
			state_d.fw_rev = fw_revision_in;
		end

		// Port events override a host write in the same cycle
		for (int c = 0; c < 4; c++) begin
			if (port_turn_off_in[c]) begin
				state_d.fold_sel[`FOLD_DFB_LSB + c] = 1'b0;
				state_d.pcut[c] = `PCUT_DEFAULT;
				state_d.fold_sel[`FOLD_HOLD_LSB + c] = 1'b0;
			end else if (port_turn_on_in[c] && !hold_eff[c]) begin
				state_d.pcut[c] = pcut_from_class(class_of(assigned_class_in, c));
				if (class_of(assigned_class_in, c) >= `CLASS_DOUBLE_MIN) begin
					state_d.fold_sel[`FOLD_DFB_LSB + c] = 1'b1;
					if (four_pair_in[c/2] && single_signature_in[c/2]
						&& !port_turn_off_in[c ^ 1]) begin
						state_d.fold_sel[`FOLD_DFB_LSB + (c ^ 1)] = 1'b1;
					end
				end else begin
					state_d.fold_sel[`FOLD_DFB_LSB + c] = 1'b0;
				end
			end
		end

		// Each channel's threshold follows its own bit only
		for (int c = 0; c < 4; c++) begin
			if (inrush_active_in[c]) begin
				state_d.thr[c] = THR_INRUSH;
			end else if (state_d.fold_sel[`FOLD_DFB_LSB + c]) begin
				state_d.thr[c] = THR_DOUBLE;
			end else begin
				state_d.thr[c] = THR_NORMAL;
			end
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_q.cmd <= 8'h00;
			state_q.idx <= IDX_LOW;
			state_q.msb_hold <= 8'h00;
			state_q.fold_sel <= `FOLD_SELECT_RESET;
			state_q.fw_rev <= `FW_REVISION_RESET;
			state_q.pcut <= {4{`PCUT_DEFAULT}};
			state_q.thr <= {4{THR_NORMAL}};
			state_q.rd_data <= 8'h00;
			state_q.rd_valid <= 1'b0;
		end else begin
			state_q <= state_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	logic [3:0] fault_q;

	// Extra stage keeps the port directly on a flop of this module
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			fault_q <= 4'h0;
		end else begin
			fault_q <= fault_raw;
		end
	end

	assign rd_byte_out = state_q.rd_data;
	assign rd_valid_out = state_q.rd_valid;
	assign double_foldback_enable_out = state_q.fold_sel[7:4];
	assign manual_policing_hold_out = state_q.fold_sel[3:0];
	assign power_cut_policing_limit_out = state_q.pcut;
	assign current_limit_threshold_out = state_q.thr;
	assign limit_fault_out = fault_q;

	////////////////////////////////////////////////////////////////////////////////

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);

	sequence s_low_read(logic [7:0] code);
		!cmd_start_in && rd_strobe_in && state_q.cmd == code && state_q.idx == IDX_LOW;
	endsequence

	sequence s_high_read;
		!cmd_start_in && rd_strobe_in && state_q.idx == IDX_HIGH;
	endsequence

	// Idle cycle between two read strobes; the snapshot must survive it
	sequence s_read_gap;
		!cmd_start_in && !rd_strobe_in;
	endsequence

	AST_CH3_LSB_FIRST: assert property (s_low_read(`CMD_CH3_VOLTAGE)
		|=> rd_valid_out && rd_byte_out == $past(ch3_count[7:0]))
		else $error("channel 3 low byte not returned first");

	AST_CH4_MSB_SECOND: assert property (s_low_read(`CMD_CH4_VOLTAGE)
		##1 s_read_gap ##1 s_high_read
		|=> rd_valid_out && rd_byte_out == $past(ch4_count[13:8], 3))
		else $error("channel 4 high byte not returned second");

	AST_VOLT_TOP_ZERO: assert property (s_low_read(`CMD_CH3_VOLTAGE)
		##1 s_read_gap ##1 s_high_read
		|=> rd_valid_out && rd_byte_out[7:6] == 2'b00)
		else $error("unused voltage bits not zero");

	AST_FOLD_WRITE: assert property (!cmd_start_in && !rd_strobe_in && wr_strobe_in
		&& state_q.cmd == `CMD_FOLD_SELECT && state_q.idx == IDX_LOW
		&& port_turn_on_in == 4'h0 && port_turn_off_in == 4'h0
		|=> state_q.fold_sel == $past(wr_byte_in))
		else $error("selection write not stored");

	AST_RO_WRITE_IGNORED: assert property (wr_strobe_in && !fw_load_in
		&& state_q.cmd == `CMD_FW_REVISION |=> $stable(state_q.fw_rev))
		else $error("revision changed by a host write");

	AST_FW_READ: assert property (s_low_read(`CMD_FW_REVISION)
		|=> rd_byte_out == $past(state_q.fw_rev))
		else $error("revision read mismatch");

	AST_TURN_ON_HIGH_CLASS: assert property (port_turn_on_in[0] && !port_turn_off_in[0]
		&& !hold_eff[0] && assigned_class_in[3:0] >= `CLASS_DOUBLE_MIN
		|=> state_q.fold_sel[4] ##1 state_q.thr[0] != THR_NORMAL)
		else $error("double foldback not set for high class");

	AST_HOLD_KEEPS: assert property (port_turn_on_in[0] && !port_turn_off_in[0]
		&& state_q.fold_sel[0] && !wr_strobe_in
		|=> $stable(state_q.fold_sel[4]) && $stable(state_q.pcut[0]))
		else $error("held channel adjusted at turn on");

	AST_FOURPAIR_HOLD: assert property (port_turn_on_in[0] && !port_turn_off_in[0]
		&& four_pair_in[0] && state_q.fold_sel[1] && !wr_strobe_in
		&& !port_turn_on_in[1] && !port_turn_off_in[1]
		|=> $stable(state_q.fold_sel[4]))
		else $error("partner hold ignored on four-pair port");

	AST_TURN_OFF_CLEARS: assert property (port_turn_off_in[2]
		|=> !state_q.fold_sel[6] && !state_q.fold_sel[2]
		&& state_q.pcut[2] == `PCUT_DEFAULT)
		else $error("turn off did not restore defaults");

	AST_INRUSH_THR: assert property (inrush_active_in[1]
		|=> state_q.thr[1] == THR_INRUSH)
		else $error("inrush profile altered by foldback bit");

endmodule : pse_voltage_foldback_regs
`default_nettype wire

// *** pse_fb_cfg.svh ***
// Command codes, field positions, reset values and timing for the foldback register slice
`ifndef PSE_FB_CFG_SVH
`define PSE_FB_CFG_SVH

`define CMD_CH3_VOLTAGE 8'h3a
`define CMD_CH4_VOLTAGE 8'h3e
`define CMD_FOLD_SELECT 8'h40
`define CMD_FW_REVISION 8'h41

`define FOLD_DFB_LSB 4
`define FOLD_HOLD_LSB 0
`define FOLD_SELECT_RESET 8'h00
`define FW_REVISION_RESET 8'h00
`define VOLT_RESET 14'h0000
`define VOLT_WIDTH 14
`define VOLT_STEP_UV 3662
`define VOLT_FULL_SCALE_V 60
`define READ_IDLE_BYTE 8'h00

`define CLASS_DOUBLE_MIN 4'h4
`define PCUT_DEFAULT 8'hff
`define PCUT_STEP 8'h0f

`define CLOCK_KHZ 200000
`define NOM_FAULT_TIME_MS 60
`define NOM_FAULT_CYCLES (`NOM_FAULT_TIME_MS * `CLOCK_KHZ)
`define FAULT_CNT_WIDTH 24

`endif

// *** pse_fb_pkg.sv ***
// Types shared by the foldback register slice
package pse_fb_pkg;

	typedef enum logic [0:0] {
		IDX_LOW = 1'b0,
		IDX_HIGH = 1'b1
	} byte_idx_t;

	typedef enum logic [1:0] {
		THR_NORMAL = 2'b00,
		THR_DOUBLE = 2'b01,
		THR_INRUSH = 2'b10
	} thr_t;

	typedef thr_t [3:0] thr_vec_t;

	typedef struct packed {
		logic [7:0] cmd;
		byte_idx_t idx;
		logic [7:0] msb_hold;
		logic [7:0] fold_sel;
		logic [7:0] fw_rev;
		logic [3:0][7:0] pcut;
		thr_vec_t thr;
		logic [7:0] rd_data;
		logic rd_valid;
	} slice_state_t;

	typedef struct packed {
		logic [23:0] count;
		logic done;
		logic fault;
	} timer_state_t;

	typedef struct packed {
		logic [13:0] count;
	} volt_state_t;

endpackage : pse_fb_pkg

// *** volt_telemetry_word.sv ***
// One read-only channel voltage word, loaded by the converter
`timescale 1ns/1ps
`default_nettype none
`include "pse_fb_cfg.svh"

module volt_telemetry_word (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic sample_in,
	input wire logic [`VOLT_WIDTH-1:0] sample_count_in,
	output logic [`VOLT_WIDTH-1:0] count_out
);
	import pse_fb_pkg::*;

	volt_state_t state_q;
	volt_state_t state_d;

	// Only the converter loads it; the host has no write path here
	always_comb begin
		state_d = state_q;
		if (sample_in) begin
			state_d.count = sample_count_in;
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_q <= '{count: `VOLT_RESET};
		end else begin
			state_q <= state_d;
		end
	end

	assign count_out = state_q.count;

endmodule : volt_telemetry_word
`default_nettype wire

// *** limit_fault_timer.sv ***
// Per-channel current-limit fault timer
`timescale 1ns/1ps
`default_nettype none
`include "pse_fb_cfg.svh"

module limit_fault_timer #(
	parameter logic [`FAULT_CNT_WIDTH-1:0] NOM_CYCLES = `FAULT_CNT_WIDTH'(`NOM_FAULT_CYCLES)
) (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic over_limit_in,
	input wire logic double_fb_in,
	input wire logic [`FAULT_CNT_WIDTH-1:0] prog_cycles_in,
	output logic fault_out
);
	import pse_fb_pkg::*;

	timer_state_t state_q;
	timer_state_t state_d;
	logic [`FAULT_CNT_WIDTH-1:0] limit;

	always_comb begin
		limit = double_fb_in ? prog_cycles_in : NOM_CYCLES;
		state_d = state_q;
		state_d.fault = 1'b0;
		if (!over_limit_in) begin
			state_d.count = '0;
			state_d.done = 1'b0;
		end else if (!state_q.done) begin
			// Runs from the first cycle over the limit in either mode
			state_d.count = state_q.count + 1'b1;
			if (state_q.count + 1'b1 >= limit) begin
				state_d.fault = 1'b1;
				state_d.done = 1'b1;
			end
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign fault_out = state_q.fault;

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);

	AST_TIMER_START: assert property ($rose(over_limit_in) |=> state_q.count == 1)
		else $error("fault timer did not start on crossing");
	AST_TIMER_EXPIRE: assert property (over_limit_in && !state_q.done
		&& (state_q.count + 1'b1 == limit) |=> state_q.fault)
		else $error("fault not raised at selected fault time");

endmodule : limit_fault_timer
`default_nettype wire

// *** host_byte_master.sv ***
// Host side model: drives byte commands, writes and reads into the register slice
`timescale 1ns/1ps
`default_nettype none

module host_byte_master (
	input wire logic clock_in,
	input wire logic [7:0] rd_byte_in,
	input wire logic rd_valid_in,
	output logic cmd_start_out,
	output logic [7:0] cmd_code_out,
	output logic wr_strobe_out,
	output logic [7:0] wr_byte_out,
	output logic rd_strobe_out
);
	initial begin
		cmd_start_out = 1'b0;
		wr_strobe_out = 1'b0;
		rd_strobe_out = 1'b0;
		cmd_code_out = 8'h00;
		wr_byte_out = 8'h00;
	end

	////////////////////////////////////////////////////////////////
	// One request for one clock, raised and dropped on falling edges
	task automatic pulse(input logic c, input logic w, input logic r, input logic [7:0] v);
		@(negedge clock_in);
		cmd_start_out = c;
		wr_strobe_out = w;
		rd_strobe_out = r;
		cmd_code_out = v;
		wr_byte_out = v;
		@(negedge clock_in);
		cmd_start_out = 1'b0;
		wr_strobe_out = 1'b0;
		rd_strobe_out = 1'b0;
		// Idle data inverted so a stale value never looks fresh
		cmd_code_out = ~v;
		wr_byte_out = ~v;
	endtask : pulse

	// Bytes come low first, taken the cycle after the strobe
	task automatic rd(output logic [8:0] vb);
		pulse(1'b0, 1'b0, 1'b1, 8'h00);
		vb = {rd_valid_in, rd_byte_in};
	endtask : rd
endmodule : host_byte_master

`default_nettype wire

// *** test_pse_voltage_foldback_regs.sv ***
// Self-checking bench for the voltage and foldback register slice
`timescale 1ns/1ps
`default_nettype none
`include "pse_fb_cfg.svh"

`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end

module test_pse_voltage_foldback_regs;
	import pse_fb_pkg::*;
	localparam int NOM = 16;
	logic clock_in, rst_n_in, cmd_start_in, wr_strobe_in, rd_strobe_in, rd_valid_out;
	logic [7:0] cmd_code_in, wr_byte_in, rd_byte_out, fw_revision_in;
	logic ch3_volt_sample_in, ch4_volt_sample_in, fw_load_in;
	logic [13:0] ch3_volt_count_in, ch4_volt_count_in, v3, v4;
	logic [3:0] port_turn_on_in, port_turn_off_in, inrush_active_in, over_limit_in;
	logic [3:0] double_foldback_enable_out, manual_policing_hold_out, limit_fault_out;
	logic [15:0] assigned_class_in;
	logic [1:0] four_pair_in, single_signature_in;
	logic [23:0] prog_fault_cycles_in;
	logic [31:0] power_cut_policing_limit_out;
	thr_vec_t current_limit_threshold_out;
	logic [7:0] sel, fwv;
	logic [7:0] pc[4];
	logic pk[4];
	int n_fail = 0;
	int n_checks = 0;
	int cyc = 0;

	pse_voltage_foldback_regs #(.NOM_FAULT_CYCLES(24'(NOM))) uut (.clock_in, .rst_n_in,
		.cmd_start_in, .cmd_code_in, .wr_strobe_in, .wr_byte_in, .rd_strobe_in,
		.rd_byte_out, .rd_valid_out, .ch3_volt_sample_in, .ch3_volt_count_in,
		.ch4_volt_sample_in, .ch4_volt_count_in, .fw_load_in, .fw_revision_in,
		.port_turn_on_in, .port_turn_off_in, .assigned_class_in, .four_pair_in,
		.single_signature_in, .inrush_active_in, .over_limit_in, .prog_fault_cycles_in,
		.double_foldback_enable_out, .manual_policing_hold_out,
		.power_cut_policing_limit_out, .current_limit_threshold_out, .limit_fault_out);

	host_byte_master m (.clock_in, .rd_byte_in(rd_byte_out), .rd_valid_in(rd_valid_out),
		.cmd_start_out(cmd_start_in), .cmd_code_out(cmd_code_in),
		.wr_strobe_out(wr_strobe_in), .wr_byte_out(wr_byte_in), .rd_strobe_out(rd_strobe_in));

	initial begin
		clock_in = 1'b0;
		forever #2.5 clock_in = ~clock_in;
	end

	task automatic give_verdict();
		$display("checks=%0d fails=%0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : give_verdict

	// Generous ceiling: the whole sequence needs about a thousand cycles
	always @(posedge clock_in) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			give_verdict();
		end
	end

	////////////////////////////////////////////////////////////////
	// Command, then n data bytes, then one spare read that must give zero
	task automatic rd_reg(input logic [7:0] c, input int n, input logic [15:0] e);
		logic [8:0] vb;
		m.pulse(1'b1, 1'b0, 1'b0, c);
		for (int i = 0; i <= n; i++) begin
			m.rd(vb);
			`CHK(vb, {1'b1, (i < n) ? e[8*i +: 8] : 8'h00})
		end
	endtask : rd_reg

	task automatic wr_reg(input logic [7:0] c, input logic [7:0] b);
		m.pulse(1'b1, 1'b0, 1'b0, c);
		m.pulse(1'b0, 1'b1, 1'b0, b);
	endtask : wr_reg

	task automatic chk_outs();
		thr_t te;
		`CHK(double_foldback_enable_out, sel[7:4])
		`CHK(manual_policing_hold_out, sel[3:0])
		for (int c = 0; c < 4; c++) begin
			te = THR_NORMAL;
			if (inrush_active_in[c]) begin
				te = THR_INRUSH;
			end else if (sel[4+c]) begin
				te = THR_DOUBLE;
			end
			if (pk[c]) `CHK(power_cut_policing_limit_out[8*c +: 8], pc[c])
			`CHK(current_limit_threshold_out[c], te)
		end
	endtask : chk_outs

	task automatic port_pulse(input int c, input logic on);
		@(negedge clock_in);
		port_turn_on_in[c] = on;
		port_turn_off_in[c] = !on;
		@(negedge clock_in);
		port_turn_on_in = 4'h0;
		port_turn_off_in = 4'h0;
		repeat (3) @(negedge clock_in);
	endtask : port_pulse

	initial begin
		int c, p, n, lim;
		logic [3:0] k;
		{rst_n_in, ch3_volt_sample_in, ch4_volt_sample_in, fw_load_in} = 4'h0;
		{ch3_volt_count_in, ch4_volt_count_in, fw_revision_in} = 36'h0;
		{port_turn_on_in, port_turn_off_in, inrush_active_in, over_limit_in} = 16'h0;
		{assigned_class_in, four_pair_in, single_signature_in} = 20'h0;
		prog_fault_cycles_in = 24'd40;
		void'($urandom(32'hc7a9));
		sel = 8'h00;
		for (int i = 0; i < 4; i++) begin
			pc[i] = 8'hff;
			pk[i] = 1'b1;
		end
		repeat (20) @(negedge clock_in);
		rst_n_in = 1'b1;
		chk_outs();
		rd_reg(`CMD_FOLD_SELECT, 1, 16'h0000);
		rd_reg(`CMD_FW_REVISION, 1, 16'h0000);
		rd_reg(`CMD_CH4_VOLTAGE, 2, 16'h0000);
		repeat (4) begin
			v3 = 14'($urandom);
			v4 = 14'($urandom);
			fwv = 8'($urandom);
			@(negedge clock_in);
			{ch3_volt_count_in, ch4_volt_count_in, fw_revision_in} = {v3, v4, fwv};
			{ch3_volt_sample_in, ch4_volt_sample_in, fw_load_in} = 3'h7;
			@(negedge clock_in);
			{ch3_volt_count_in, ch4_volt_count_in, fw_revision_in} = ~{v3, v4, fwv};
			{ch3_volt_sample_in, ch4_volt_sample_in, fw_load_in} = 3'h0;
			wr_reg(`CMD_CH3_VOLTAGE, ~v3[7:0]);
			wr_reg(`CMD_FW_REVISION, ~fwv);
			rd_reg(`CMD_CH3_VOLTAGE, 2, {2'b00, v3});
			rd_reg(`CMD_CH4_VOLTAGE, 2, {2'b00, v4});
			rd_reg(`CMD_FW_REVISION, 1, {8'h00, fwv});
		end
		////////////////////////////////////////////////////////////////
		repeat (30) begin
			c = $urandom_range(3);
			p = c / 2;
			sel = 8'($urandom);
			wr_reg(`CMD_FOLD_SELECT, sel);
			rd_reg(`CMD_FOLD_SELECT, 1, {8'h00, sel});
			assigned_class_in = 16'($urandom);
			four_pair_in = 2'($urandom);
			single_signature_in = 2'($urandom);
			inrush_active_in = 4'($urandom);
			// Equal classes keep the single-signature partner bit unambiguous
			if (four_pair_in[p] && single_signature_in[p])
				assigned_class_in[4*(c^1) +: 4] = assigned_class_in[4*c +: 4];
			k = assigned_class_in[4*c +: 4];
			if (!(sel[c] || (four_pair_in[p] && sel[c^1]))) begin
				sel[4+c] = (k >= 4'h4);
				pc[c] = 8'(k * 15);
				pk[c] = 1'b1;
				// Partner bit is only ever raised; its policing value is untouched
				if (four_pair_in[p] && single_signature_in[p] && k >= 4'h4) begin
					sel[4+(c^1)] = 1'b1;
				end
			end
			port_pulse(c, 1'b1);
			chk_outs();
			c = $urandom_range(3);
			sel[4+c] = 1'b0;
			sel[c] = 1'b0;
			pc[c] = 8'hff;
			pk[c] = 1'b1;
			port_pulse(c, 1'b0);
			chk_outs();
			rd_reg(`CMD_FOLD_SELECT, 1, {8'h00, sel});
		end
		////////////////////////////////////////////////////////////////
		inrush_active_in = 4'h0;
		for (int d = 0; d < 2; d++) begin
			wr_reg(`CMD_FOLD_SELECT, d ? 8'hf0 : 8'h00);
			c = $urandom_range(3);
			lim = d ? 40 : NOM;
			n = 0;
			@(negedge clock_in);
			over_limit_in[c] = 1'b1;
			while (n < 200 && limit_fault_out[c] !== 1'b1) begin
				@(negedge clock_in);
				n++;
			end
			`CHK(1'(n >= lim && n <= lim + 4), 1'b1)
			over_limit_in = 4'h0;
		end
		give_verdict();
	end
endmodule : test_pse_voltage_foldback_regs

`default_nettype wire
